/* sim/asrc_host_checker.sv */
/*
 * Concurrent checks on the pins and request port of the SRAM host controller.
 * Assumes it is bound to asrc_host and sees only that module's ports.
 */
`include "asrc_params.svh"
`default_nettype none

module asrc_host_checker
  import asrc_pkg::*;
(
  // Clock and reset
  input wire logic                    clk_sys_i,
  input wire logic                    rst_i,
  // Request side
  input wire logic                    req_valid_i,
  input wire logic                    req_ready_o,
  input wire asrc_req_t               req_i,
  input wire logic                    rd_valid_o,
  input wire logic                    retain_req_i,
  input wire logic                    retain_ack_o,
  // SRAM pins
  input wire asrc_ctl_t               ctl_o,
  input wire logic [`ASRC_ADDR_W-1:0] word_addr_o,
  input wire logic [`ASRC_DATA_W-1:0] data_pins_o,
  input wire logic [`ASRC_DATA_W-1:0] data_pins_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // ===================================================================
  // Helpers
  // ===================================================================
  wire take     = req_valid_i && req_ready_o && (req_i.lanes != 2'h0);
  wire cs_n     = ctl_o.chip_select_n;
  wire oe_n     = ctl_o.output_enable_n;
  wire we_n     = ctl_o.write_strobe_n;
  wire sel      = !cs_n;
  wire lane_on  = !(ctl_o.low_lane_sel_n && ctl_o.high_lane_sel_n);
  wire drv_all  = &data_pins_oe_o;
  wire drv_none = (data_pins_oe_o == 16'h0000);
  sequence s_wr_on;
    sel && !we_n && lane_on;
  endsequence
  sequence s_busy2;
    !req_ready_o [*2];
  endsequence

  // ===================================================================
  // Assertions
  // ===================================================================
  AST_RD_WE_HIGH: assert property (sel && !oe_n |-> we_n)
    else $error("write strobe low while output enabled");
  AST_NO_FIGHT: assert property (!oe_n |-> drv_none)
    else $error("host drives data while SRAM outputs enabled");
  AST_WR_DRIVE: assert property (s_wr_on |-> oe_n && drv_all)
    else $error("write without output disable or data drive");
  AST_WR_START: assert property (take && req_i.write |-> ##[1:2] s_wr_on)
    else $error("write request never opened a write");
  AST_WR_END: assert property ($rose(we_n) |-> $rose(cs_n))
    else $error("write not ended by strobe and select together");
  AST_WR_HOLD: assert property ($rose(we_n) |-> drv_all && $stable(data_pins_o))
    else $error("write data not held over the ending edge");
  AST_LANE_LEAD: assert property ($fell(we_n) |-> sel && lane_on)
    else $error("strobe fell without select and lane");
  AST_WE_WIDTH: assert property (s_wr_on |=> we_n)
    else $error("write strobe width not one cycle");
  AST_ADDR_HOLD: assert property (sel && !$fell(cs_n) |-> $stable(word_addr_o))
    else $error("address moved while selected");
  AST_RETAIN_DESEL: assert property (retain_ack_o |-> cs_n)
    else $error("select low during retention");
  AST_RECOVER: assert property (retain_ack_o && !retain_req_i |-> !req_ready_o)
    else $error("ready during retention recovery");
  AST_RD_ANSWER: assert property (take && !req_i.write |=> s_busy2 ##[1:3] rd_valid_o)
    else $error("read answer missing or early");
  AST_WR_BUSY: assert property (take && req_i.write |=> s_busy2)
    else $error("write cycle shortened");
endmodule

bind asrc_host asrc_host_checker asrc_host_checker_inst (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o), .req_i(req_i), .rd_valid_o(rd_valid_o),
  .retain_req_i(retain_req_i), .retain_ack_o(retain_ack_o), .ctl_o(ctl_o),
  .word_addr_o(word_addr_o), .data_pins_o(data_pins_o), .data_pins_oe_o(data_pins_oe_o)
);

`default_nettype wire

/* sim/asrc_sram_model.sv */
/*
 * Behavioural model of the 256K x 16 static RAM, seen from its pins.
 * Assumes the bench feeds it the host pins and uses bus_o as the data wire.
 */
`include "asrc_params.svh"
`default_nettype none

module asrc_sram_model
  import asrc_pkg::*;
(
  // Clock, only to vary the released bus
  input  wire logic                    clk_sys_i,
  // Host pins
  input  wire asrc_ctl_t               ctl_i,
  input  wire logic [`ASRC_ADDR_W-1:0] addr_i,
  input  wire logic [`ASRC_DATA_W-1:0] hd_i,
  input  wire logic [`ASRC_DATA_W-1:0] hoe_i,
  // Resolved data wire
  output logic [`ASRC_DATA_W-1:0]      bus_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Static storage, no refresh
  logic [15:0] mem [0:262143];
  logic [15:0] flt = 16'h0000;
  logic [1:0]  ln  = 2'h0;
  logic [17:0] wa  = 18'h00000;
  // Mode decode
  wire sel      = !ctl_i.chip_select_n;
  wire lane_any = !(ctl_i.low_lane_sel_n && ctl_i.high_lane_sel_n);
  wire wr_act   = sel && !ctl_i.write_strobe_n && lane_any;
  // Drives only while selected, enabled and strobe high
  wire rd       = sel && !ctl_i.output_enable_n && ctl_i.write_strobe_n;
  wire dev_hi   = rd && !ctl_i.high_lane_sel_n;
  wire dev_lo   = rd && !ctl_i.low_lane_sel_n;
  wire [15:0] dev_en = {{8{dev_hi}}, {8{dev_lo}}};
  // Released bits wander every cycle, the bus has no pull
  always @(posedge clk_sys_i) flt <= {flt[14:0], ~flt[15]};
  // Read word follows the address at once
  assign bus_o = (hoe_i & hd_i) | (~hoe_i & dev_en & mem[addr_i])
               | (~hoe_i & ~dev_en & flt);
  // Lanes and address noted while the write is open
  always @* if (wr_act) begin
    ln = ~{ctl_i.high_lane_sel_n, ctl_i.low_lane_sel_n};
    wa = addr_i;
  end
  // Bytes land at the edge that ends the write
  always @(negedge wr_act) begin
    if (ln[0]) mem[wa][7:0] = bus_o[7:0];
    if (ln[1]) mem[wa][15:8] = bus_o[15:8];
  end
endmodule

`default_nettype wire

/* sim/tb.sv */
/*
 * Self-checking bench for the SRAM host controller.
 * Assumes the SRAM model and the bound checker are compiled before it.
 */
`include "asrc_params.svh"
`default_nettype none

module tb;
  import asrc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ===================================================================
  // Signals and bookkeeping
  // ===================================================================
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        req_valid_i = 1'b0;
  logic        retain_req_i = 1'b0;
  asrc_req_t   req_i = '0;
  logic        req_ready_o, rd_valid_o, retain_ack_o;
  logic [15:0] rd_data_o, data_pins_i, data_pins_o, data_pins_oe_o;
  logic [17:0] word_addr_o;
  asrc_ctl_t   ctl_o;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;
  logic [31:0] seed = 32'h56bb0f58;
  logic [15:0] exp_q [$];
  logic [15:0] sh [logic [17:0]];

  asrc_host asrc_host_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_i(req_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .retain_req_i(retain_req_i), .retain_ack_o(retain_ack_o), .ctl_o(ctl_o),
    .word_addr_o(word_addr_o), .data_pins_i(data_pins_i), .data_pins_o(data_pins_o),
    .data_pins_oe_o(data_pins_oe_o));
  asrc_sram_model asrc_sram_model_inst (.clk_sys_i(clk_sys_i), .ctl_i(ctl_o),
    .addr_i(word_addr_o), .hd_i(data_pins_o), .hoe_i(data_pins_oe_o), .bus_o(data_pins_i));

  // ===================================================================
  // Helpers
  // ===================================================================
  initial forever #25 clk_sys_i = ~clk_sys_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Present one request, hold it until taken, note the expected answer
  task automatic req(input logic w, input logic [17:0] a, input logic [15:0] d,
                     input logic [1:0] l);
    @(negedge clk_sys_i);
    req_valid_i = 1'b1;
    req_i = '{write: w, word_addr: a, wdata: d, lanes: l};
    do @(posedge clk_sys_i); while (req_ready_o !== 1'b1);
    if (w) begin
      if (l[0]) sh[a][7:0] = d[7:0];
      if (l[1]) sh[a][15:8] = d[15:8];
    end else if (l != 2'h0) begin
      exp_q.push_back({l[1] ? sh[a][15:8] : 8'h00, l[0] ? sh[a][7:0] : 8'h00});
    end
  endtask
  task automatic drain();
    @(negedge clk_sys_i);
    req_valid_i = 1'b0;
    repeat (10) @(negedge clk_sys_i);
    chk(16'(exp_q.size()), 16'h0000);
  endtask
  // Compare each read answer with the oldest note
  always @(negedge clk_sys_i) begin
    if (!rst_i && rd_valid_o === 1'b1) begin
      if (exp_q.size() == 0) chk({15'h0, rd_valid_o}, 16'h0000);
      else chk(rd_data_o, exp_q.pop_front());
    end
  end
  // Cut a hang short
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ===================================================================
  // Main sequence
  // ===================================================================
  initial begin
    logic [17:0] a;
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    // Corner addresses, then every write lane and read lane mix
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      a = (i == 0) ? 18'h00000 : (i == 1) ? 18'h3ffff : seed[17:0];
      req(1'b1, a, seed[31:16], 2'h3);
      req(1'b1, a, seed[15:0], i[1:0]);
      req(1'b0, a, 16'h0000, i[3:2]);
    end
    drain();
    $display("test lanes done");
    // Retention with a read waiting, then back to back reads
    retain_req_i = 1'b1;
    fork
      req(1'b0, 18'h3ffff, 16'h0000, 2'h3);
      begin
        repeat (4) @(negedge clk_sys_i);
        chk({15'h0, retain_ack_o}, 16'h0001);
        chk({15'h0, ctl_o.chip_select_n}, 16'h0001);
        chk({15'h0, req_ready_o}, 16'h0000);
        retain_req_i = 1'b0;
      end
    join
    req(1'b0, 18'h00000, 16'h0000, 2'h3);
    req(1'b0, 18'h3ffff, 16'h0000, 2'h1);
    drain();
    $display("test retention done");
    report_and_stop();
  end
endmodule

`default_nettype wire

/* verilog/asrc_host.sv */
/*
 * Host controller for a 256K x 16 asynchronous static RAM.
 * Assumes the SRAM answers on data_pins_i with no clock of its own;
 * that input is resynchronised by two flops before use.
 * Reads answer four cycles after the take; writes free the port after two.
 * Unselected read lanes come back as zero.
 */
// Contract
// - Host holds write strobe high during reads
// - Address valid by chip select fall
// - Write starts all active, first release ends
// - Host holds write strobe low 35 ns
// - Lane select active 35 ns before end
// - Retention: select high, wait recovery time
`include "asrc_params.svh"
`default_nettype none

module asrc_host
  import asrc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  // User request port
  input  wire logic                    req_valid_i,
  output logic                         req_ready_o,
  input  wire asrc_req_t               req_i,
  // User read answer
  output logic                         rd_valid_o,
  output logic [`ASRC_DATA_W-1:0]      rd_data_o,
  // Power-down handshake
  input  wire logic                    retain_req_i,
  output logic                         retain_ack_o,
  // SRAM pins
  output var  asrc_ctl_t               ctl_o,
  output logic [`ASRC_ADDR_W-1:0]      word_addr_o,
  input  wire logic [`ASRC_DATA_W-1:0] data_pins_i,
  output logic [`ASRC_DATA_W-1:0]      data_pins_o,
  output logic [`ASRC_DATA_W-1:0]      data_pins_oe_o
);

  // ===================================================================
  // State record
  // ===================================================================
  typedef struct packed {
    asrc_state_t             state;
    logic [`ASRC_CNT_W-1:0]  cnt;
    logic [`ASRC_ADDR_W-1:0] addr;
    logic [`ASRC_DATA_W-1:0] wdata;
    logic [1:0]              lanes;
    logic                    rd_valid;
    logic [`ASRC_DATA_W-1:0] rd_data;
    logic [`ASRC_DATA_W-1:0] sync1;
    logic [`ASRC_DATA_W-1:0] sync2;
  } host_t;

  host_t st_q;
  host_t st_d;

  // Next pin values, registered by the pin stage
  asrc_ctl_t               ctl_n;
  logic [`ASRC_ADDR_W-1:0] addr_n;
  logic                    doe_n;

  // Cycle count of a phase minus one, for the down counter
  function automatic logic [`ASRC_CNT_W-1:0] cyc_load(input int unsigned cyc);
    cyc_load = `ASRC_CNT_W'(cyc - 1);
  endfunction

  // One step down of the phase counter
  function automatic logic [`ASRC_CNT_W-1:0] cyc_dec(input logic [`ASRC_CNT_W-1:0] c);
    cyc_dec = c - `ASRC_CNT_W'(1);
  endfunction

  // Merge read lanes into the answer; unselected lanes read as zero
  function automatic logic [`ASRC_DATA_W-1:0] lane_mask(
    input logic [`ASRC_DATA_W-1:0] d,
    input logic [1:0]              l
  );
    lane_mask = {(l[1] ? d[`ASRC_DATA_W-1:`ASRC_LANE_W] : `ASRC_LANE_W'(0)),
                 (l[0] ? d[`ASRC_LANE_W-1:0]            : `ASRC_LANE_W'(0))};
  endfunction

  // ===================================================================
  // Sequencer
  // ===================================================================
  always_comb begin
    st_d          = st_q;
    st_d.rd_valid = 1'b0;
    st_d.sync1    = data_pins_i;             // Two-flop resync of pins
    st_d.sync2    = st_q.sync1;
    ctl_n         = '1;                      // Deselected by default
    addr_n        = st_q.addr;
    doe_n         = 1'b0;
    case (st_q.state)
      ST_IDLE: begin
        if (retain_req_i) begin
          st_d.state = ST_RETN;              // Select stays high
          // Recovery count starts fresh on every entry
          st_d.cnt   = cyc_load(`ASRC_REC_CYC);
        end else if (req_valid_i && (req_i.lanes != 2'h0)) begin
          // Empty lane mask is dropped: it would change nothing
          st_d.addr  = req_i.word_addr;      // Address set before select
          st_d.wdata = req_i.wdata;
          st_d.lanes = req_i.lanes;
          addr_n     = req_i.word_addr;
          if (req_i.write) begin
            st_d.state = ST_WRITE;
            st_d.cnt   = cyc_load(`ASRC_WR_CYC);
          end else begin
            st_d.state = ST_READ;
            // Pin stage and two resync flops sit between select and sample
            st_d.cnt   = cyc_load(`ASRC_RD_CYC + `ASRC_SYNC_CYC);
          end
        end
      end
      ST_READ: begin
        // Strobe held high throughout the read
        ctl_n.chip_select_n   = 1'b0;
        ctl_n.output_enable_n = 1'b0;
        ctl_n.low_lane_sel_n  = ~st_q.lanes[0];
        ctl_n.high_lane_sel_n = ~st_q.lanes[1];
        if (st_q.cnt == '0) begin
          st_d.rd_valid = 1'b1;
          st_d.rd_data  = lane_mask(st_q.sync2, st_q.lanes);
          st_d.state    = ST_RHIZ;
          st_d.cnt      = cyc_load(`ASRC_HZ_CYC);             // Release gap
        end else begin
          st_d.cnt = cyc_dec(st_q.cnt);
        end
      end
      ST_RHIZ: begin
        // Bus turnaround: device lets go before any host drive
        if (st_q.cnt == '0) begin
          st_d.state = ST_IDLE;
        end else begin
          st_d.cnt = cyc_dec(st_q.cnt);
        end
      end
      ST_WRITE: begin
        // Output enable high keeps the device off the bus
        ctl_n.chip_select_n   = 1'b0;
        ctl_n.write_strobe_n  = 1'b0;
        ctl_n.low_lane_sel_n  = ~st_q.lanes[0];
        ctl_n.high_lane_sel_n = ~st_q.lanes[1];
        doe_n                 = 1'b1;
        if (st_q.cnt == '0) begin
          st_d.state = ST_WEND;              // Strobe low long enough
        end else begin
          st_d.cnt = cyc_dec(st_q.cnt);
        end
      end
      ST_WEND: begin
        // Strobe and select rise together; data held one more cycle
        doe_n      = 1'b1;
        st_d.state = ST_IDLE;
      end
      ST_RETN: begin
        // Recovery wait before next access after retention
        if (retain_req_i) begin
          st_d.cnt = cyc_load(`ASRC_REC_CYC);
        end else if (st_q.cnt == '0) begin
          st_d.state = ST_IDLE;
        end else begin
          st_d.cnt = cyc_dec(st_q.cnt);
        end
      end
      default: begin
        st_d.state = ST_IDLE;
      end
    endcase
    if (rst_i) begin
      st_d       = '0;
      st_d.state = ST_IDLE;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    st_q <= st_d;
  end

  // ===================================================================
  // Outputs
  // ===================================================================
  // Ready drops as soon as retention is asked for, so no access can
  // slip in between the request and the deselect
  assign req_ready_o  = (st_q.state == ST_IDLE) && !retain_req_i;
  assign rd_valid_o   = st_q.rd_valid;
  assign rd_data_o    = st_q.rd_data;
  assign retain_ack_o = (st_q.state == ST_RETN);

  // Registered pin stage
  asrc_pin_drv u_pin (
    .clk_sys_i      (clk_sys_i),
    .rst_i          (rst_i),
    .ctl_i          (ctl_n),
    .addr_i         (addr_n),
    .dout_i         (st_q.wdata),
    .doe_i          (doe_n),
    .ctl_o          (ctl_o),
    .word_addr_o    (word_addr_o),
    .data_pins_o    (data_pins_o),
    .data_pins_oe_o (data_pins_oe_o)
  );

endmodule

`default_nettype wire

/* verilog/asrc_params.svh */
/*
 * Timing and geometry constants for the asynchronous SRAM host port.
 * Assumes a 20 MHz system clock (50 ns period); counts derive from it.
 */
`ifndef ASRC_PARAMS_SVH
`define ASRC_PARAMS_SVH

// =====================================================================
// Geometry
// =====================================================================
`define ASRC_ADDR_W      18
`define ASRC_DATA_W      16
`define ASRC_LANE_W      8

// =====================================================================
// Timing in ns, and the clock period
// =====================================================================
`define ASRC_CLK_PERIOD_NS  50
`define ASRC_T_RC_NS        45
`define ASRC_T_AA_NS        45
`define ASRC_T_WC_NS        45
`define ASRC_T_PWE_NS       35
`define ASRC_T_PWB_NS       35
`define ASRC_T_SD_NS        25
`define ASRC_T_HZWE_NS      20
`define ASRC_T_RDR_NS       45

// Least times round up, never below one cycle
`define ASRC_CYC_UP(ns) (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_CYC_MIN1(ns) ((`ASRC_CYC_UP(ns) < 1) ? 1 : `ASRC_CYC_UP(ns))

`define ASRC_RD_CYC    `ASRC_CYC_MIN1(`ASRC_T_AA_NS)
`define ASRC_WR_CYC    `ASRC_CYC_MIN1(`ASRC_T_PWE_NS)
`define ASRC_HZ_CYC    `ASRC_CYC_MIN1(`ASRC_T_HZWE_NS)
`define ASRC_REC_CYC   `ASRC_CYC_MIN1(`ASRC_T_RDR_NS)
// Edges the pin stage and the two resync flops add to a read
`define ASRC_SYNC_CYC  3
`define ASRC_CNT_W     4

`endif

/* verilog/asrc_pin_drv.sv */
/*
 * Registered pin stage for the SRAM data bus and control pins.
 * Assumes the caller decides drive enables; this stage only registers them.
 */
`include "asrc_params.svh"
`default_nettype none

module asrc_pin_drv
  import asrc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  // Next pin values
  input  wire asrc_ctl_t               ctl_i,
  input  wire logic [`ASRC_ADDR_W-1:0] addr_i,
  input  wire logic [`ASRC_DATA_W-1:0] dout_i,
  input  wire logic                    doe_i,
  // Pins
  output var  asrc_ctl_t               ctl_o,
  output logic [`ASRC_ADDR_W-1:0]      word_addr_o,
  output logic [`ASRC_DATA_W-1:0]      data_pins_o,
  output logic [`ASRC_DATA_W-1:0]      data_pins_oe_o
);

  typedef struct packed {
    asrc_ctl_t               ctl;
    logic [`ASRC_ADDR_W-1:0] addr;
    logic [`ASRC_DATA_W-1:0] dout;
    logic                    oe;
  } drv_t;

  drv_t st_q;
  drv_t st_d;

  // ===================================================================
  // Next value, deselected and released under reset
  // ===================================================================
  always_comb begin
    st_d.ctl  = ctl_i;
    st_d.addr = addr_i;
    st_d.dout = dout_i;
    st_d.oe   = doe_i;
    if (rst_i) begin
      st_d = '0;
      st_d.ctl = '1;
    end
  end

  // Register stage
  always_ff @(posedge clk_sys_i) begin
    st_q <= st_d;
  end

  // Outputs straight from flip-flops
  assign ctl_o          = st_q.ctl;
  assign word_addr_o    = st_q.addr;
  assign data_pins_o    = st_q.dout;
  assign data_pins_oe_o = {`ASRC_DATA_W{st_q.oe}};

endmodule

`default_nettype wire

/* verilog/asrc_pkg.sv */
/*
 * Types shared by the SRAM host controller and its pin driver.
 * Assumes asrc_params.svh is on the include path.
 */
`include "asrc_params.svh"
`default_nettype none

package asrc_pkg;

  // ===================================================================
  // Control pins, all active low
  // ===================================================================
  typedef struct packed {
    logic                    chip_select_n;
    logic                    output_enable_n;
    logic                    write_strobe_n;
    logic                    low_lane_sel_n;
    logic                    high_lane_sel_n;
  } asrc_ctl_t;

  // ===================================================================
  // User request
  // ===================================================================
  typedef struct packed {
    logic                    write;
    logic [`ASRC_ADDR_W-1:0] word_addr;
    logic [`ASRC_DATA_W-1:0] wdata;
    logic [1:0]              lanes;    // bit0 low lane, bit1 high lane
  } asrc_req_t;

  // ===================================================================
  // Sequencer states
  // ===================================================================
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_RHIZ  = 6'h02,
    ST_READ  = 6'h04,
    ST_WRITE = 6'h08,
    ST_WEND  = 6'h10,
    ST_RETN  = 6'h20
  } asrc_state_t;

endpackage

`default_nettype wire
